// File: src/prc_run_control.sv
// Run command register bank with identity readback and options
`timescale 1ns/1ps
`default_nettype none
module prc_run_control #(
  parameter logic [15:0] PART_CODE = 16'h5A01, // Arbitrary value
  parameter logic [15:0] PART_REV = 16'h0A03, // Arbitrary value
  parameter int CNT_W = 16
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic cmd_valid, // Command strobe
  input wire logic cmd_write, // 1 write, 0 read
  input wire logic [7:0] cmd_code, // Command code
  input wire logic [15:0] cmd_wdata, // Write data
  input wire logic [1:0] cmd_index, // Read byte index
  output logic [7:0] rd_data, // Read byte
  output logic rd_valid, // Read answer pulse
  input wire logic enable_pin, // Enable pin level
  input wire logic enable_active_high, // Pin polarity
  input wire logic cmd_response, // Run bit obeyed
  input wire logic pin_response, // Pin must be asserted
  input wire logic input_undervoltage_lockout, // Input too low
  input wire logic fault_present, // Any fault
  input wire logic overvoltage_fault, // Overvoltage detected
  input wire logic below_uv_threshold, // Output below UV
  input wire logic voltage_strap_valid, // Strap detection ok
  input wire logic [CNT_W-1:0] turnoff_delay_setting, // Delay cycles
  input wire logic [CNT_W-1:0] soft_stop_fall_time, // Fall cycles
  input wire logic cml_clear, // Clear comm fault flags
  output logic switching_enable, // Output switching on
  output logic high_side_drive, // High driver enable
  output logic low_side_drive, // Low driver enable
  output logic ramp_down, // Soft fall active
  output logic [1:0] margin_select, // Run bits 5:4, always 00 (nom) since run writes mask them off
  output logic cml_fault, // Comm fault summary
  output logic invalid_data, // Invalid data flag
  output logic smbalert_n, // Alert, active low
  output logic reset_pin_mode, // Shared pin is reset
  output logic [15:0] options_out, // Option register
  output logic [15:0] misc_out // Misc option register
);
  import prc_pkg::*;
  // ==========================================================
  // Registers
  logic [7:0] run_reg;
  logic [15:0] scratch_reg;
  logic [15:0] options_reg;
  logic [15:0] misc_reg;
  logic pin_prev_reg;
  logic running_reg;
  logic ov_latch_reg;
  logic run_upd_reg;
  logic run_wr;
  logic bad_wr;
  logic pin_on;
  logic want_on;
  logic turn_off;
  logic soft_start;
  logic in_delay;
  logic in_fall;
  logic stop_done;
  logic [15:0] word;
  logic [7:0] rd_next;

  assign run_wr = cmd_valid && cmd_write && (cmd_code == CMD_RUN);
  // Both run and soft-off set is invalid
  assign bad_wr = run_wr && cmd_wdata[RUN_BIT] && cmd_wdata[SOFT_OFF_BIT];
  assign pin_on = enable_pin ~^ enable_active_high;
  // Gating of run request
  assign want_on = (cmd_response ? run_reg[RUN_BIT] : 1'b1) &&
                   (!pin_response || pin_on) &&
                   !input_undervoltage_lockout && !fault_present;

  // ==========================================================
  // Register writes
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      run_reg <= RUN_RESET;
      scratch_reg <= SCRATCH_RESET;
      options_reg <= OPTIONS_RESET;
      misc_reg <= MISC_RESET;
    end else if (cmd_valid && cmd_write) begin
      // Identity codes have no write path
      if (cmd_code == CMD_RUN && !bad_wr) begin
        run_reg <= cmd_wdata[7:0] & RUN_WRITE_MASK;
      end else if (cmd_code == CMD_SCRATCH) begin
        scratch_reg <= cmd_wdata;
      end else if (cmd_code == CMD_OPTIONS) begin
        options_reg <= cmd_wdata;
      end else if (cmd_code == CMD_MISC) begin
        misc_reg <= cmd_wdata;
      end
    end
  end

  // ==========================================================
  // Communication fault flags and alert, set wins over clear
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cml_fault <= 1'b0;
      invalid_data <= 1'b0;
      smbalert_n <= 1'b1;
    end else if (bad_wr) begin
      cml_fault <= 1'b1;
      invalid_data <= 1'b1;
      smbalert_n <= 1'b0;
    end else if (cml_clear) begin
      cml_fault <= 1'b0;
      invalid_data <= 1'b0;
      smbalert_n <= 1'b1;
    end
  end

  // ==========================================================
  // Read answer: block reads give count then low, high
  always_comb begin
    word = 16'h0000;
    rd_next = UNMAPPED_DATA;
    if (cmd_code == CMD_PART_CODE) begin
      word = PART_CODE;
    end else if (cmd_code == CMD_PART_REV) begin
      word = PART_REV;
    end else if (cmd_code == CMD_SCRATCH) begin
      word = scratch_reg;
    end else if (cmd_code == CMD_OPTIONS) begin
      word = options_reg;
    end else if (cmd_code == CMD_MISC) begin
      word = misc_reg;
    end
    if (cmd_code == CMD_RUN) begin
      rd_next = run_reg;
    end else if (cmd_code == CMD_PART_CODE || cmd_code == CMD_PART_REV) begin
      if (cmd_index == 2'd0) begin
        rd_next = BLOCK_COUNT;
      end else if (cmd_index == 2'd1) begin
        rd_next = word[7:0];
      end else begin
        rd_next = word[15:8];
      end
    end else if (cmd_code == CMD_SCRATCH || cmd_code == CMD_OPTIONS ||
                 cmd_code == CMD_MISC) begin
      rd_next = cmd_index[0] ? word[15:8] : word[7:0];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= cmd_valid && !cmd_write;
      if (cmd_valid && !cmd_write) begin
        rd_data <= rd_next;
      end
    end
  end

  // ==========================================================
  // Run state: holds until new write, pin edge, lockout or fault
  assign turn_off = running_reg && !want_on &&
                    (run_upd_reg || (pin_prev_reg != enable_pin) ||
                     input_undervoltage_lockout || fault_present);
  assign soft_start = turn_off && run_reg[SOFT_OFF_BIT] && !fault_present;

  // Marks the cycle after a stored run write, so gating sees the new bits
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      run_upd_reg <= 1'b0;
    end else begin
      run_upd_reg <= run_wr && !bad_wr;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      running_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= enable_pin;
      if (!running_reg && want_on && !in_delay && !in_fall) begin
        running_reg <= 1'b1;
      end else if (turn_off) begin
        running_reg <= 1'b0;
      end
    end
  end

  prc_soft_stop #(.CNT_W(CNT_W)) u_soft_stop (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(soft_start),
    .abort(fault_present),
    .delay_cycles(turnoff_delay_setting),
    .fall_cycles(soft_stop_fall_time),
    .in_delay(in_delay),
    .in_fall(in_fall),
    .done(stop_done)
  );

  // ==========================================================
  // Overvoltage low side latch, released below UV
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ov_latch_reg <= 1'b0;
    end else if (overvoltage_fault) begin
      ov_latch_reg <= 1'b1;
    end else if (below_uv_threshold && misc_reg[MISC_OV_RESP_BIT]) begin
      ov_latch_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      switching_enable <= 1'b0;
      high_side_drive <= 1'b0;
      low_side_drive <= 1'b0;
      ramp_down <= 1'b0;
      margin_select <= 2'b00;
      reset_pin_mode <= 1'b0;
      options_out <= OPTIONS_RESET;
      misc_out <= MISC_RESET;
    end else begin
      // Running, or still in delay or fall phase of soft stop, and the overvoltage latch clear
      switching_enable <= !ov_latch_reg &&
                          (running_reg || in_delay || in_fall);
      high_side_drive <= !ov_latch_reg &&
                         (running_reg || in_delay || in_fall);
      low_side_drive <= ov_latch_reg;
      ramp_down <= in_fall;
      margin_select <= run_reg[MARGIN_LO+1:MARGIN_LO];
      reset_pin_mode <= misc_reg[MISC_RESET_PIN_BIT] &&
                        voltage_strap_valid;
      options_out <= options_reg;
      misc_out <= misc_reg;
    end
  end

  // ==========================================================
  // Assertions
  a_invalid_alert: assert property (@(posedge clk_sys) disable iff (reset)
    bad_wr |=> !smbalert_n && invalid_data && cml_fault)
    else $error("invalid run write not flagged");
  a_invalid_nostore: assert property (@(posedge clk_sys) disable iff (reset)
    bad_wr |=> $stable(run_reg))
    else $error("invalid run write stored");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (reset)
    run_reg[5:0] == 6'h00)
    else $error("reserved run bits nonzero");
  a_part_count: assert property (@(posedge clk_sys) disable iff (reset)
    cmd_valid && !cmd_write && cmd_code == CMD_PART_CODE && cmd_index == 2'd0
    |=> rd_valid && rd_data == BLOCK_COUNT)
    else $error("part code count wrong");
  a_rev_low: assert property (@(posedge clk_sys) disable iff (reset)
    cmd_valid && !cmd_write && cmd_code == CMD_PART_REV && cmd_index == 2'd1
    |=> rd_data == PART_REV[7:0])
    else $error("revision low byte wrong");
  a_off_drivers: assert property (@(posedge clk_sys) disable iff (reset)
    !running_reg && !in_delay && !in_fall |=> !high_side_drive)
    else $error("driver on while off");
  a_hard_stop: assert property (@(posedge clk_sys) disable iff (reset)
    turn_off && !run_reg[SOFT_OFF_BIT] ##1 !in_delay && !in_fall
    |=> !switching_enable)
    else $error("hard stop not immediate");
  a_soft_delay: assert property (@(posedge clk_sys) disable iff (reset)
    soft_start |=> in_delay)
    else $error("soft stop delay missing");
  a_ov_low_side: assert property (@(posedge clk_sys) disable iff (reset)
    overvoltage_fault |=> ##1 low_side_drive && !high_side_drive)
    else $error("overvoltage low side not on");
  a_lockout_block: assert property (@(posedge clk_sys) disable iff (reset)
    input_undervoltage_lockout && !running_reg |=> !running_reg)
    else $error("started under lockout");
  a_ignore_run: assert property (@(posedge clk_sys) disable iff (reset)
    !cmd_response && !input_undervoltage_lockout && !fault_present &&
    (!pin_response || pin_on) && running_reg |=> running_reg)
    else $error("run bit not ignored");
  a_write_stop: assert property (@(posedge clk_sys) disable iff (reset)
    running_reg && run_upd_reg && cmd_response && !run_reg[RUN_BIT]
    |=> !running_reg)
    else $error("run write of zero did not stop");
  a_hold_mode: assert property (@(posedge clk_sys) disable iff (reset)
    running_reg && !run_upd_reg && pin_prev_reg == enable_pin &&
    !input_undervoltage_lockout && !fault_present |=> running_reg)
    else $error("mode changed without event");
  a_part_low: assert property (@(posedge clk_sys) disable iff (reset)
    cmd_valid && !cmd_write && cmd_code == CMD_PART_CODE && cmd_index == 2'd1
    |=> rd_data == PART_CODE[7:0])
    else $error("part code low byte wrong");
  a_part_high: assert property (@(posedge clk_sys) disable iff (reset)
    cmd_valid && !cmd_write && cmd_code == CMD_PART_CODE && cmd_index == 2'd2
    |=> rd_data == PART_CODE[15:8])
    else $error("part code high byte wrong");
  a_rev_high: assert property (@(posedge clk_sys) disable iff (reset)
    cmd_valid && !cmd_write && cmd_code == CMD_PART_REV && cmd_index == 2'd2
    |=> rd_data == PART_REV[15:8])
    else $error("revision high byte wrong");
  a_run_read: assert property (@(posedge clk_sys) disable iff (reset)
    cmd_valid && !cmd_write && cmd_code == CMD_RUN
    |=> rd_valid && rd_data[5:0] == 6'h00)
    else $error("reserved run bits read nonzero");
  a_ov_release: assert property (@(posedge clk_sys) disable iff (reset)
    !overvoltage_fault && below_uv_threshold && misc_reg[MISC_OV_RESP_BIT]
    |=> ##1 !low_side_drive)
    else $error("low side not released below UV");
  a_flag_clear: assert property (@(posedge clk_sys) disable iff (reset)
    cml_clear && !bad_wr |=> smbalert_n && !cml_fault && !invalid_data)
    else $error("comm fault flags not cleared");
  c_start: cover property (@(posedge clk_sys) disable iff (reset)
    !running_reg ##1 running_reg);
  c_soft_stop: cover property (@(posedge clk_sys) disable iff (reset)
    stop_done);
  c_invalid: cover property (@(posedge clk_sys) disable iff (reset)
    bad_wr);
  c_ov: cover property (@(posedge clk_sys) disable iff (reset)
    $fell(ov_latch_reg));
endmodule // prc_run_control
`default_nettype wire

// File: src/prc_pkg.sv
// Package of constants for the serial-bus run control register bank
`default_nettype none
package prc_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_RUN = 8'h01;
  localparam logic [7:0] CMD_PART_CODE = 8'hAD;
  localparam logic [7:0] CMD_PART_REV = 8'hAE;
  localparam logic [7:0] CMD_SCRATCH = 8'hD0;
  localparam logic [7:0] CMD_OPTIONS = 8'hE5;
  localparam logic [7:0] CMD_MISC = 8'hF0;
  // ==========================================================
  // Fields and reset values
  localparam int RUN_BIT = 7;
  localparam int SOFT_OFF_BIT = 6;
  localparam int MARGIN_LO = 4;
  localparam int MISC_OV_RESP_BIT = 0;
  localparam int MISC_RESET_PIN_BIT = 0;
  localparam logic [7:0] RUN_WRITE_MASK = 8'hC0;
  localparam logic [7:0] RUN_RESET = 8'h00;
  localparam logic [15:0] SCRATCH_RESET = 16'h0000;
  localparam logic [15:0] OPTIONS_RESET = 16'h00C7;
  localparam logic [15:0] MISC_RESET = 16'h0001;
  localparam logic [7:0] BLOCK_COUNT = 8'h02;
  // ==========================================================
  // Read strobe answers and run states
  localparam logic [7:0] UNMAPPED_DATA = 8'hFF;
  typedef enum logic [1:0] {
    PRC_OFF = 2'b00,
    PRC_RUN = 2'b01,
    PRC_DELAY = 2'b11,
    PRC_FALL = 2'b10
  } prc_state_type;
endpackage
`default_nettype wire

// File: src/prc_soft_stop.sv
// Soft stop sequencer: turn-off delay then fall ramp
`timescale 1ns/1ps
`default_nettype none
module prc_soft_stop #(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Async reset, active high
  input wire logic start, // Begin soft stop pulse
  input wire logic abort, // Cancel sequence
  input wire logic [CNT_W-1:0] delay_cycles, // Turn-off delay count
  input wire logic [CNT_W-1:0] fall_cycles, // Fall ramp count
  output logic in_delay, // Waiting the delay
  output logic in_fall, // Ramping down
  output logic done // One-cycle end pulse
);
  import prc_pkg::*;
  logic [CNT_W-1:0] count_reg;
  prc_state_type state_reg;
  // ==========================================================
  // Delay then ramp counting
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= PRC_OFF;
      count_reg <= '0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        state_reg <= PRC_OFF;
      end else if (start) begin
        state_reg <= PRC_DELAY;
        count_reg <= delay_cycles;
      end else begin
        case (state_reg)
          PRC_DELAY: begin
            if (count_reg == '0) begin
              state_reg <= PRC_FALL;
              count_reg <= fall_cycles;
            end else begin
              count_reg <= count_reg - 1'b1;
            end
          end
          PRC_FALL: begin
            if (count_reg == '0) begin
              state_reg <= PRC_OFF;
              done <= 1'b1;
            end else begin
              count_reg <= count_reg - 1'b1;
            end
          end
          default: state_reg <= PRC_OFF;
        endcase
      end
    end
  end
  assign in_delay = (state_reg == PRC_DELAY);
  assign in_fall = (state_reg == PRC_FALL);
endmodule // prc_soft_stop
`default_nettype wire

// File: verif/prc_host_model.sv
// Host model issuing command reads and writes to the register bank
`timescale 1ns/1ps
`default_nettype none
module prc_host_model (
  input wire logic clk_sys, // System clock
  output logic cmd_valid, // Command strobe
  output logic cmd_write, // Write select
  output logic [7:0] cmd_code, // Command code
  output logic [15:0] cmd_wdata, // Write data
  output logic [1:0] cmd_index, // Read byte index
  input wire logic [7:0] rd_data, // Read byte
  input wire logic rd_valid // Read answer pulse
);
  import prc_pkg::*;
  // ==========================================================
  // Bus idle state
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    cmd_index = 2'h0;
  end
  // Released lines show inverted values
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_code = ~cmd_code;
    cmd_wdata = ~cmd_wdata;
    cmd_index = ~cmd_index;
  endtask
  // ==========================================================
  // Write, dropping run plus soft-off unless asked for
  task automatic wr(input logic [7:0] code, input logic [15:0] data,
                    input logic bad_ok);
    @(negedge clk_sys);
    if (code != CMD_RUN || !(data[7] && data[6]) || bad_ok) begin
      cmd_valid = 1'b1;
      cmd_write = 1'b1;
      cmd_code = code;
      cmd_wdata = data;
      @(negedge clk_sys);
      idle();
    end
  endtask
  // Read one byte, waiting a bounded time for the answer
  task automatic rd(input logic [7:0] code, input logic [1:0] idx,
                    output logic [7:0] data);
    int n;
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_write = 1'b0;
    cmd_code = code;
    cmd_index = idx;
    @(negedge clk_sys);
    idle();
    n = 0;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    data = (rd_valid === 1'b1) ? rd_data : 8'hXX;
  endtask
endmodule // prc_host_model
`default_nettype wire

// File: verif/prc_run_control_tb.sv
// Testbench for the run control register bank
`timescale 1ns/1ps
`default_nettype none
module prc_run_control_tb;
  import prc_pkg::*;
  localparam logic [15:0] PC = 16'h3C12; // Arbitrary value
  localparam logic [15:0] PR = 16'h0B04; // Arbitrary value
  localparam int CW = 8;
  logic clk_sys, reset, cmd_valid, cmd_write, rd_valid;
  logic [7:0] cmd_code, rd_data;
  logic [15:0] cmd_wdata, options_out, misc_out;
  logic [1:0] cmd_index, margin_select;
  logic enable_pin, pin_pol, cmd_response, pin_response, lockout;
  logic fault_present, ov_fault, below_uv, strap_ok, cml_clear;
  logic [CW-1:0] dly, fall;
  logic switching_enable, high_side_drive, low_side_drive, ramp_down;
  logic cml_fault, invalid_data, smbalert_n, reset_pin_mode;
  int n_fail = 0;
  int compares = 0;
  int n_ramp = 0;
  int cyc = 0;
  prc_host_model u_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_index(cmd_index), .rd_data(rd_data), .rd_valid(rd_valid));
  prc_run_control #(.PART_CODE(PC), .PART_REV(PR), .CNT_W(CW)) u_dut (
    .clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_index(cmd_index), .rd_data(rd_data), .rd_valid(rd_valid),
    .enable_pin(enable_pin), .enable_active_high(pin_pol),
    .cmd_response(cmd_response), .pin_response(pin_response),
    .input_undervoltage_lockout(lockout), .fault_present(fault_present),
    .overvoltage_fault(ov_fault), .below_uv_threshold(below_uv),
    .voltage_strap_valid(strap_ok), .turnoff_delay_setting(dly),
    .soft_stop_fall_time(fall), .cml_clear(cml_clear),
    .switching_enable(switching_enable),
    .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
    .ramp_down(ramp_down), .margin_select(margin_select),
    .cml_fault(cml_fault), .invalid_data(invalid_data),
    .smbalert_n(smbalert_n), .reset_pin_mode(reset_pin_mode),
    .options_out(options_out), .misc_out(misc_out));
  // ==========================================================
  // Clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  // Counts cycles spent ramping down
  always @(negedge clk_sys) begin
    if (ramp_down === 1'b1) n_ramp++;
  end
  // ==========================================================
  // Checking and access helpers
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("n_fail %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic rd_word(input logic [7:0] code, output logic [15:0] w);
    u_host.rd(code, 2'h0, w[7:0]);
    u_host.rd(code, 2'h1, w[15:8]);
  endtask
  task automatic rd_blk(input logic [7:0] code, input logic [15:0] exp);
    logic [7:0] b;
    u_host.rd(code, 2'h0, b);
    chk("block count", b, BLOCK_COUNT);
    u_host.rd(code, 2'h1, b);
    chk("block low", b, exp[7:0]);
    u_host.rd(code, 2'h2, b);
    chk("block high", b, exp[15:8]);
  endtask
  task automatic wait_se(input logic exp, input int n);
    for (int i = 0; i < n && switching_enable !== exp; i++)
      @(negedge clk_sys);
    chk("switching_enable", switching_enable, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] c;
    logic [15:0] w;
    logic [7:0] rw [3];
    rw = '{CMD_SCRATCH, CMD_OPTIONS, CMD_MISC};
    reset = 1'b1;
    {enable_pin, pin_pol, pin_response, lockout, fault_present} = 5'h08;
    {ov_fault, below_uv, strap_ok, cml_clear} = 4'h0;
    cmd_response = 1'b1;
    dly = 8'h03;
    fall = 8'h04;
    tick(3);
    reset = 1'b0;
    chk("options_out", options_out, OPTIONS_RESET);
    chk("misc_out", misc_out, MISC_RESET);
    chk("smbalert_n", smbalert_n, 1'b1);
    chk("high_side_drive", high_side_drive, 1'b0);
    rd_blk(CMD_PART_CODE, PC);
    rd_blk(CMD_PART_REV, PR);
    u_host.wr(CMD_PART_CODE, 16'hFFFF, 1'b0);
    u_host.wr(CMD_PART_REV, 16'h0000, 1'b0);
    rd_blk(CMD_PART_CODE, PC);
    rd_blk(CMD_PART_REV, PR);
    rd_word(CMD_OPTIONS, w);
    chk("options", w, OPTIONS_RESET);
    rd_word(CMD_MISC, w);
    chk("misc", w, MISC_RESET);
    rd_word(CMD_SCRATCH, w);
    chk("scratch", w, SCRATCH_RESET);
    for (int k = 0; k < 3; k++) begin
      u_host.wr(rw[k], 16'hA55A, 1'b0);
      rd_word(rw[k], w);
      chk("rw word", w, 16'hA55A);
      u_host.wr(rw[k], MISC_RESET, 1'b0);
    end
    u_host.rd(8'h55, 2'h0, c);
    chk("unmapped", c, UNMAPPED_DATA);
    // Start, hold, hard stop
    u_host.wr(CMD_RUN, 16'h00BF, 1'b0);
    wait_se(1'b1, 6);
    chk("high_side_drive", high_side_drive, 1'b1);
    u_host.rd(CMD_RUN, 2'h0, c);
    chk("run readback", c, 8'h80);
    chk("margin_select", margin_select, 2'b00);
    tick(20);
    chk("switching_enable", switching_enable, 1'b1);
    n_ramp = 0;
    u_host.wr(CMD_RUN, 16'h0000, 1'b0);
    wait_se(1'b0, 3);
    chk("ramp cycles", n_ramp, 0);
    chk("low_side_drive", low_side_drive, 1'b0);
    // Soft stop with delay and fall ramp
    u_host.wr(CMD_RUN, 16'h0080, 1'b0);
    wait_se(1'b1, 6);
    n_ramp = 0;
    u_host.wr(CMD_RUN, 16'h0040, 1'b0);
    tick(2);
    chk("switching_enable", switching_enable, 1'b1);
    wait_se(1'b0, 30);
    chk("ramp cycles", n_ramp, fall + 1);
    // Invalid run plus soft-off write
    u_host.wr(CMD_RUN, 16'h00C0, 1'b1);
    tick(2);
    chk("cml_fault", cml_fault, 1'b1);
    chk("invalid_data", invalid_data, 1'b1);
    chk("smbalert_n", smbalert_n, 1'b0);
    u_host.rd(CMD_RUN, 2'h0, c);
    chk("run readback", c, 8'h40);
    cml_clear = 1'b1;
    tick(1);
    cml_clear = 1'b0;
    tick(2);
    chk("smbalert_n", smbalert_n, 1'b1);
    chk("cml_fault", cml_fault, 1'b0);
    chk("invalid_data", invalid_data, 1'b0);
    // Gating by lockout and fault
    lockout = 1'b1;
    u_host.wr(CMD_RUN, 16'h0080, 1'b0);
    tick(6);
    chk("switching_enable", switching_enable, 1'b0);
    lockout = 1'b0;
    wait_se(1'b1, 6);
    fault_present = 1'b1;
    wait_se(1'b0, 4);
    fault_present = 1'b0;
    u_host.wr(CMD_RUN, 16'h0000, 1'b0);
    wait_se(1'b0, 4);
    // Run bit ignored: pin not required, so the converter runs
    cmd_response = 1'b0;
    wait_se(1'b1, 6);
    u_host.wr(CMD_RUN, 16'h0000, 1'b0);
    tick(6);
    chk("switching_enable", switching_enable, 1'b1);
    cmd_response = 1'b1;
    u_host.wr(CMD_RUN, 16'h0000, 1'b0);
    wait_se(1'b0, 4);
    // Enable pin edge turns off
    cmd_response = 1'b1;
    pin_response = 1'b1;
    enable_pin = 1'b1;
    u_host.wr(CMD_RUN, 16'h0080, 1'b0);
    wait_se(1'b1, 6);
    enable_pin = 1'b0;
    wait_se(1'b0, 40);
    // Overvoltage low-side hold and strap
    ov_fault = 1'b1;
    tick(3);
    chk("low_side_drive", low_side_drive, 1'b1);
    ov_fault = 1'b0;
    tick(3);
    chk("low_side_drive", low_side_drive, 1'b1);
    below_uv = 1'b1;
    tick(3);
    chk("low_side_drive", low_side_drive, 1'b0);
    strap_ok = 1'b1;
    tick(3);
    chk("reset_pin_mode", reset_pin_mode, 1'b1);
    finish_test();
  end
endmodule // prc_run_control_tb
`default_nettype wire
